// ---- verilog/uart_rx_pkg.sv ----
// Constants and types for the serial receiver front end
package uart_rx_pkg;
  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int RX_EN_BIT = 0;
  localparam int DS_BIT = 1;
  localparam int AF_BIT = 2;
  localparam int CS_LSB = 3;
  localparam int PM_LSB = 6;
  localparam int ST_RXC = 0;
  localparam int ST_FE = 1;
  localparam int ST_PE = 2;
  localparam int ST_OVR = 3;
  localparam int ST_B8 = 4;
  // ----------------------------------------------------------
  // Buffer entry layout
  // ----------------------------------------------------------
  localparam int ENT_W = 12;
  localparam int ENT_FE = 9;
  localparam int ENT_PE = 10;
  localparam int ENT_OVR = 11;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  // ----------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] VFIRST_NORMAL = 5'h08;
  localparam logic [4:0] VLAST_NORMAL = 5'h0A;
  localparam logic [4:0] VFIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VLAST_DOUBLE = 5'h06;
  localparam logic [2:0] NINE_BIT_CODE = 3'h7;
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS,
    RX_REARM
  } rx_state_type;
endpackage : uart_rx_pkg

// ---- verilog/uart_rx_recovery.sv ----
// Serial receiver with start validation, voting and address filter
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Sample line at 16x baud, or 8x when double speed is selected.
// - A high-to-low line change starts detection; first low is sample 1.
// - Start validated on samples 8,9,10 normal, or 4,5,6 double speed.
// - Two or more high validation samples reject start; wait again.
// - Bit timing resynchronises on every valid start bit.
// - Sixteen or eight sample states per bit, numbered by state.
// - Each bit is the majority of its three centre samples.
// - Recover bits through the first stop bit; ignore later stops.
// - Stop bit voted too; zero sets the stop-bit error flag.
// - Normal mode rearms right after stop vote; double speed later.
// - Data plus parity bits may total five to ten.
// - With filter enabled, data frames are dropped, never buffered.
// - Filter affects reception only, never transmission.
// - Frame type is first stop bit, or ninth bit in nine-bit frames.
// - Frame type one means address frame, zero means data frame.
// - Address frames under filtering are stored and flagged as usual.
// - Overrun when buffer full, frame waiting and new start seen.
// - Disabling receiver is immediate, abandons frame, empties buffer.
// - Parity checked only if mode high bit set; low bit picks odd.
module uart_rx_recovery (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic sample_tick,
  input wire logic serial_in_line,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    uart_rx_pkg::rx_state_type st;
    logic [4:0] cnt;
    logic [3:0] bit_idx;
    logic last_line;
    logic [1:0] votes;
    logic [8:0] shreg;
    logic par_bit;
    logic [1:0][uart_rx_pkg::ENT_W-1:0] fifo;
    logic [1:0] count;
    logic rd_ptr;
    logic pend_valid;
    logic [uart_rx_pkg::ENT_W-1:0] pend;
    logic ovr_pend;
    logic [7:0] ctrl;
    logic [7:0] ph_addr;
    logic ph_wr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } state_type;

  state_type s;
  state_type n;

  logic rx_en, ds, af_en, nine, par_en, maj, line;
  logic start_ok, done, drop, xfer, pop, ftype, par_err, valid;
  logic [2:0] cs;
  logic [1:0] pm;
  logic [3:0] dbits, stop_idx;
  logic [4:0] spb, vfirst, vlast;
  logic [uart_rx_pkg::ENT_W-1:0] head, entry;

  assign line = serial_in_line;
  assign rx_en = s.ctrl[uart_rx_pkg::RX_EN_BIT];
  assign ds = s.ctrl[uart_rx_pkg::DS_BIT];
  assign af_en = s.ctrl[uart_rx_pkg::AF_BIT];
  assign cs = s.ctrl[uart_rx_pkg::CS_LSB +: 3];
  assign pm = s.ctrl[uart_rx_pkg::PM_LSB +: 2];
  assign nine = cs == uart_rx_pkg::NINE_BIT_CODE;
  // five to nine data bits, optional parity
  assign dbits = nine ? 4'h9 : cs[2] ? 4'h8 : 4'h5 + {2'h0, cs[1:0]};
  assign par_en = pm[1];
  assign stop_idx = dbits + {3'h0, par_en};
  assign spb = ds ? uart_rx_pkg::SPB_DOUBLE : uart_rx_pkg::SPB_NORMAL;
  assign vfirst = ds ? uart_rx_pkg::VFIRST_DOUBLE
                     : uart_rx_pkg::VFIRST_NORMAL;
  assign vlast = ds ? uart_rx_pkg::VLAST_DOUBLE : uart_rx_pkg::VLAST_NORMAL;
  assign maj = (s.votes[1] & s.votes[0]) | (s.votes[1] & line) |
               (s.votes[0] & line);
  // parity error only when checking is on
  assign par_err = par_en & (pm[0] ? ~(^s.shreg ^ s.par_bit)
                                   : (^s.shreg ^ s.par_bit));
  assign head = s.fifo[s.rd_ptr];
  assign valid = hsel & htrans[1] & hready;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    n = s;
    start_ok = 1'b0;
    done = 1'b0;
    drop = 1'b0;
    xfer = 1'b0;
    pop = 1'b0;
    ftype = 1'b0;
    entry = '0;
    // Bus address phase and registered read data
    n.ph_wr = valid & hwrite;
    n.ph_addr = haddr[7:0];
    n.hrdata = 32'h00000000;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
    if (valid && !hwrite) begin
      if (haddr[7:0] == uart_rx_pkg::CTRL_OFS) begin
        n.hrdata = {24'h000000, s.ctrl};
      end else if (haddr[7:0] == uart_rx_pkg::STATUS_OFS) begin
        if (s.count != 2'h0) begin
          // flags follow the frame at the read position
          n.hrdata[uart_rx_pkg::ST_RXC] = 1'b1;
          n.hrdata[uart_rx_pkg::ST_FE] = head[uart_rx_pkg::ENT_FE];
          n.hrdata[uart_rx_pkg::ST_PE] = head[uart_rx_pkg::ENT_PE];
          n.hrdata[uart_rx_pkg::ST_OVR] = head[uart_rx_pkg::ENT_OVR];
          n.hrdata[uart_rx_pkg::ST_B8] = head[8];
        end
      end else if (haddr[7:0] == uart_rx_pkg::DATA_OFS) begin
        if (s.count != 2'h0) begin
          n.hrdata = {23'h000000, head[8:0]};
          pop = 1'b1;
        end
      end
    end
    if (s.ph_wr && s.ph_addr == uart_rx_pkg::CTRL_OFS) begin
      n.ctrl = hwdata[7:0];
    end
    if (sample_tick) begin
      n.last_line = line;
    end
    // all recovery steps advance on the sample tick
    if (rx_en && sample_tick) begin
      if ((s.st == uart_rx_pkg::RX_START || s.st == uart_rx_pkg::RX_BITS)
          && s.cnt >= vfirst && s.cnt < vlast) begin
        n.votes = {s.votes[0], line};
      end
      case (s.st)
        uart_rx_pkg::RX_IDLE: begin
          // falling edge is sample 1, next tick takes sample 2
          if (s.last_line && !line) begin
            n.st = uart_rx_pkg::RX_START;
            n.cnt = 5'h02;
          end
        end
        uart_rx_pkg::RX_START: begin
          n.cnt = s.cnt + 5'h01;
          if (s.cnt == vlast) begin
            if (maj) begin
              n.st = uart_rx_pkg::RX_IDLE;
            end else begin
              // bit timing restarts from this start bit
              start_ok = 1'b1;
              n.st = uart_rx_pkg::RX_BITS;
              n.bit_idx = 4'h0;
              n.shreg = 9'h000;
              n.par_bit = 1'b0;
            end
          end
        end
        uart_rx_pkg::RX_BITS: begin
          // sample state wraps once per bit
          n.cnt = (s.cnt == spb) ? 5'h01 : s.cnt + 5'h01;
          if (s.cnt == vlast) begin
            n.bit_idx = s.bit_idx + 4'h1;
            if (s.bit_idx < dbits) begin
              n.shreg[s.bit_idx] = maj;
            end else if (s.bit_idx < stop_idx) begin
              n.par_bit = maj;
            end else begin
              // frame ends at first stop bit
              done = 1'b1;
              // normal rearms now, double speed one sample on
              n.st = ds ? uart_rx_pkg::RX_REARM : uart_rx_pkg::RX_IDLE;
            end
          end
        end
        uart_rx_pkg::RX_REARM: begin
          n.st = uart_rx_pkg::RX_IDLE;
        end
        default: begin
          n.st = uart_rx_pkg::RX_IDLE;
        end
      endcase
    end
    // frame type source by frame size
    ftype = nine ? s.shreg[8] : maj;
    // data frames dropped while filtering; receive side only
    // type one is an address, kept as requires
    drop = af_en & ~ftype;
    // zero stop bit marks the entry
    entry = {1'b0, par_err, ~maj, s.shreg};
    // Waiting frame moves into the two-entry buffer when room exists
    xfer = s.pend_valid & ((s.count != uart_rx_pkg::BUF_DEPTH) | pop);
    if (xfer) begin
      n.fifo[s.rd_ptr ^ s.count[0]] = s.pend |
        {s.ovr_pend, {(uart_rx_pkg::ENT_W - 1){1'b0}}};
      n.ovr_pend = 1'b0;
      n.pend_valid = 1'b0;
    end
    if (pop) begin
      n.rd_ptr = ~s.rd_ptr;
    end
    n.count = s.count + {1'b0, xfer} - {1'b0, pop};
    if (done && !drop && (!s.pend_valid || xfer)) begin
      // stop error kept with its frame
      n.pend = entry;
      n.pend_valid = 1'b1;
    end
    // overrun on new start while full and a frame waits
    if (start_ok && s.pend_valid && s.count == uart_rx_pkg::BUF_DEPTH &&
        !pop) begin
      n.ovr_pend = 1'b1;
    end
    // disable abandons frame and flushes buffer
    if (!rx_en) begin
      n.st = uart_rx_pkg::RX_IDLE;
      n.count = 2'h0;
      n.pend_valid = 1'b0;
      n.ovr_pend = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.last_line <= 1'b1;
      s.ctrl <= uart_rx_pkg::CTRL_RESET;
      s.hreadyout <= 1'b1;
    end else if (clk_en) begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign hrdata = s.hrdata;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  start_detect_a: assert property (
    clk_en && rx_en && sample_tick && s.st == uart_rx_pkg::RX_IDLE &&
    s.last_line && !line |=> s.st == uart_rx_pkg::RX_START &&
    s.cnt == 5'h02) else $error("start not opened on falling edge");
  noise_reject_a: assert property (
    clk_en && rx_en && sample_tick && s.st == uart_rx_pkg::RX_START &&
    s.cnt == vlast && maj |=> s.st == uart_rx_pkg::RX_IDLE)
    else $error("noisy start accepted");
  vote_point_a: assert property (
    start_ok |-> s.cnt == (ds ? 5'h06 : 5'h0A))
    else $error("start voted at wrong sample");
  resync_a: assert property (
    clk_en && start_ok |=> s.st == uart_rx_pkg::RX_BITS &&
    s.bit_idx == 4'h0 && s.shreg == 9'h000)
    else $error("bit timing not restarted");
  cnt_bound_a: assert property (
    s.st == uart_rx_pkg::RX_BITS |-> s.cnt >= 5'h01 && s.cnt <= spb)
    else $error("sample state out of range");
  filter_drop_a: assert property (
    clk_en && done && af_en && !ftype && !s.pend_valid && rx_en
    |=> !s.pend_valid) else $error("data frame kept while filtering");
  addr_keep_a: assert property (
    clk_en && done && ftype && !s.pend_valid && rx_en |=> s.pend_valid)
    else $error("address frame lost");
  rearm_a: assert property (
    clk_en && done && !ds && rx_en |=> s.st == uart_rx_pkg::RX_IDLE)
    else $error("normal mode not rearmed after stop");
  overrun_a: assert property (
    clk_en && rx_en && start_ok && s.pend_valid && !pop &&
    s.count == 2'h2 |=> s.ovr_pend) else $error("overrun missed");
  flush_a: assert property (
    clk_en && !rx_en |=> s.count == 2'h0 && !s.pend_valid &&
    s.st == uart_rx_pkg::RX_IDLE) else $error("disable did not flush");
  stop_err_a: assert property (
    clk_en && rx_en && done && !maj && !drop && !s.pend_valid
    |=> s.pend[uart_rx_pkg::ENT_FE]) else $error("stop error not kept");
endmodule : uart_rx_recovery

// ---- verification/serial_tx_model.sv ----
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module serial_tx_model (
  input wire logic core_clk,
  input wire logic sample_tick,
  output logic line
);
  initial begin
    line = 1'b1;
  end
  // exact rate
  // Tick-exact bit timing, no rate error
  task put(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge core_clk iff sample_tick === 1'b1);
  endtask : put
  // frame layout
  // Start, bits LSB first, first stop, extra stops high
  task send(input logic [9:0] b, input int nb, input int spb,
    input logic stp, input int ns);
    int i;
    put(1'b0, spb);
    for (i = 0; i < nb; i++) begin
      put(b[i], spb);
    end
    put(stp, spb);
    for (i = 1; i < ns; i++) begin
      put(1'b1, spb);
    end
  endtask : send
endmodule : serial_tx_model

// ---- verification/uart_rx_recovery_address_filter_bit_filter_test.sv ----
// Self-checking bench for the serial receiver front end
`timescale 1ns/1ps
module uart_rx_recovery_address_filter_bit_filter_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sample_tick = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rd_ph = 1'b0;
  logic [1:0] tk = 2'h0;
  wire logic hreadyout;
  wire logic hresp;
  wire logic serial_in_line;
  wire logic [31:0] hrdata;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int seed = 32'h3a682302;
  logic [7:0] d;
  logic [7:0] e;
  uart_rx_recovery i_dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .sample_tick(sample_tick), .serial_in_line(serial_in_line),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  serial_tx_model i_tx (.core_clk(core_clk), .sample_tick(sample_tick),
    .line(serial_in_line));
  // ----------------------------------------------------------
  // Clock, tick, timeout and result watcher
  // ----------------------------------------------------------
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    tk <= tk + 2'h1;
    sample_tick <= (tk == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      conclude();
    end
    if (rd_ph && hreadyout === 1'b1) begin
      chk(nm_q.pop_front(), hrdata, exp_q.pop_front());
      chk("hresp", {31'h0, hresp}, 32'h0);
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // Write data or expected read value in v
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v,
    input string nm);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= v;
    if (!w) begin
      exp_q.push_back(v);
      nm_q.push_back(nm);
      rd_ph <= 1'b1;
    end
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask : bus
  task frame(input logic [7:0] c, input logic [9:0] b, input int nb,
    input int spb, input logic stp, input int ns, input logic [31:0] st,
    input logic [31:0] dt, input string nm);
    bus(1'b1, uart_rx_pkg::CTRL_OFS, {24'h0, c}, "");
    i_tx.send(b, nb, spb, stp, ns);
    i_tx.put(1'b1, 4);
    bus(1'b0, uart_rx_pkg::STATUS_OFS, st, {nm, " status"});
    bus(1'b0, uart_rx_pkg::DATA_OFS, dt, {nm, " data"});
    $display("test %s done", nm);
  endtask : frame
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, uart_rx_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    bus(1'b0, uart_rx_pkg::STATUS_OFS, 32'h0, "status reset");
    bus(1'b1, 8'h0C, 32'hFF, "");
    bus(1'b0, 8'h0C, 32'h0, "unmapped");
    bus(1'b0, uart_rx_pkg::DATA_OFS, 32'h0, "empty data");
    d = 8'($random(seed));
    e = 8'($random(seed));
    frame(8'h19, {2'h0, d}, 8, 16, 1'b1, 1, 32'h1, d, "normal");
    frame(8'h19, {2'h0, e}, 8, 16, 1'b0, 1, 32'h3, e, "stop err");
    frame(8'h1B, {2'h0, d}, 8, 8, 1'b1, 1, 32'h1, d, "double");
    frame(8'h99, {1'b0, ~^e, e}, 9, 16, 1'b1, 1, 32'h5, e, "parity");
    frame(8'hB9, {^d, 1'b0, d}, 10, 16, 1'b1, 1, 32'h1, d, "ten");
    frame(8'h3D, {2'h1, e}, 9, 16, 1'b1, 1, 32'h11, {24'h1, e},
      "address");
    frame(8'h39, {2'h0, d}, 9, 16, 1'b1, 1, 32'h1, d, "selected");
    frame(8'h3D, {2'h0, d}, 9, 16, 1'b1, 1, 32'h0, 32'h0, "drop");
    frame(8'h05, {5'h0, e[4:0]}, 5, 16, 1'b1, 2, 32'h1, e[4:0],
      "short addr");
    frame(8'h05, {5'h0, d[4:0]}, 5, 16, 1'b0, 2, 32'h0, 32'h0,
      "short drop");
    bus(1'b1, uart_rx_pkg::CTRL_OFS, 32'h19, "");
    i_tx.put(1'b0, 3);
    i_tx.put(1'b1, 30);
    bus(1'b0, uart_rx_pkg::STATUS_OFS, 32'h0, "glitch");
    i_tx.send({2'h0, d}, 8, 16, 1'b1, 1);
    i_tx.send({2'h0, e}, 8, 16, 1'b1, 1);
    i_tx.send({2'h0, d}, 8, 16, 1'b1, 1);
    i_tx.send({2'h0, e}, 8, 16, 1'b1, 1);
    i_tx.put(1'b1, 4);
    bus(1'b0, uart_rx_pkg::STATUS_OFS, 32'h1, "b2b status");
    bus(1'b0, uart_rx_pkg::DATA_OFS, {24'h0, d}, "b2b first");
    bus(1'b0, uart_rx_pkg::DATA_OFS, {24'h0, e}, "b2b second");
    bus(1'b0, uart_rx_pkg::STATUS_OFS, 32'h9, "ovr status");
    bus(1'b0, uart_rx_pkg::DATA_OFS, {24'h0, d}, "ovr data");
    bus(1'b0, uart_rx_pkg::STATUS_OFS, 32'h0, "ovr lost");
    i_tx.send({2'h0, d}, 8, 16, 1'b1, 1);
    i_tx.put(1'b1, 4);
    bus(1'b1, uart_rx_pkg::CTRL_OFS, 32'h0, "");
    bus(1'b0, uart_rx_pkg::STATUS_OFS, 32'h0, "flushed");
    $display("test serial sequences done");
    @(posedge core_clk);
    conclude();
  end
endmodule : uart_rx_recovery_address_filter_bit_filter_test
